// [verilog/sram_host_params.svh]
`ifndef SRAM_HOST_PARAMS_SVH
`define SRAM_HOST_PARAMS_SVH

// Timing figures in ns, slow grade as the safe default
`define WRITE_WINDOW_WIDTH_NS      50
`define SELECT_TO_WRITE_END_NS     60
`define ADDRESS_LEAD_TO_WRITE_NS   0
`define WRITE_RECOVERY_GAP_NS      0
`define DESELECT_TO_RETENTION_NS   0
`define READ_ACCESS_NS             70
`define RELEASE_DELAY_NS           25
`define CLOCK_PERIOD_NS            40

// Least times round up to whole cycles, never below one
`define CYCLES_UP(ns) ((((ns) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS) < 1 ? 1 : \
	(((ns) + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS))

`define WRITE_WINDOW_CYCLES  `CYCLES_UP(`SELECT_TO_WRITE_END_NS)
`define READ_ACCESS_CYCLES   `CYCLES_UP(`READ_ACCESS_NS)
`define RELEASE_CYCLES       `CYCLES_UP(`RELEASE_DELAY_NS)

`endif

// [verilog/sram_host_pkg.sv]
package sram_host_pkg;
	typedef enum logic [2:0] {
		IDLE    = 3'b000,
		SETUP   = 3'b001,
		WINDOW  = 3'b010,
		RECOVER = 3'b011,
		READ    = 3'b100,
		RELEASE = 3'b101,
		RETAIN  = 3'b110
	} host_state_t;
endpackage

// [verilog/cycle_timer.sv]
`timescale 1ns/100ps
module cycle_timer #(
	parameter int WIDTH = 4
) (
	input  wire logic             clock,
	input  wire logic             rst,
	input  wire logic             load,
	input  wire logic [WIDTH-1:0] count,
	output logic                  done
);
	logic [WIDTH-1:0] remaining;

	// A zero-width counter cannot time anything
	if (WIDTH < 1) begin : g_bad_width
		$error("cycle_timer needs a width of at least one bit");
	end

	// Counts down from the loaded value; done while zero
	always_ff @(posedge clock) begin
		if (rst) begin
			remaining <= '0;
		end else if (load) begin
			remaining <= count;
		end else if (remaining != '0) begin
			remaining <= remaining - 1'b1;
		end
	end

	assign done = (remaining == '0);
endmodule

// [verilog/sram_host.sv]
`timescale 1ns/100ps
`include "sram_host_params.svh"
module sram_host #(
	parameter int ADDR_WIDTH = 18,
	parameter int DATA_WIDTH = 16
) (
	input  wire logic                  clock,
	input  wire logic                  rst,
	input  wire logic                  reqValid,
	input  wire logic                  reqWrite,
	input  wire logic [1:0]            reqLanes,
	input  wire logic [ADDR_WIDTH-1:0] reqAddress,
	input  wire logic [DATA_WIDTH-1:0] reqData,
	input  wire logic                  retainRequest,
	output logic                       reqReady,
	output logic                       readValid,
	output logic [DATA_WIDTH-1:0]      readData,
	output logic                       retainActive,
	output logic [ADDR_WIDTH-1:0]      word_address,
	output logic                       select_active_low,
	output logic                       select_active_high,
	output logic                       writeStrobe_n,
	output logic                       outputGate_n,
	output logic                       low_lane_select_n,
	output logic                       high_lane_select_n,
	input  wire logic [DATA_WIDTH-1:0] shared_data_bus_in,
	output logic [DATA_WIDTH-1:0]      shared_data_bus_out,
	output logic [DATA_WIDTH-1:0]      shared_data_bus_oe
);
	import sram_host_pkg::*;

	localparam int TW = 4;

	// Pin map and lane split are built for these widths; timer must hold the write window and read access counts
	if (ADDR_WIDTH != 18 || DATA_WIDTH != 16 || `WRITE_WINDOW_CYCLES > (1 << TW)
		|| `READ_ACCESS_CYCLES > (1 << TW)) begin : g_bad_config
		$error("sram_host serves an 18-bit address and 16-bit data only");
	end

	host_state_t      state;
	logic             timerLoad;
	logic [TW-1:0]    timerCount;
	logic             timerDone;
	logic             opWrite;
	logic [1:0]       opLanes;

	// Spreads lane selects into a per-line enable mask
	function automatic logic [DATA_WIDTH-1:0] laneMask(input logic [1:0] lanes);
		laneMask = {{(DATA_WIDTH/2){lanes[1]}}, {(DATA_WIDTH/2){lanes[0]}}};
	endfunction

	cycle_timer #(.WIDTH(TW)) timer (
		.clock (clock),
		.rst   (rst),
		.load  (timerLoad),
		.count (timerCount),
		.done  (timerDone)
	);

	// Sequencer: one access at a time, no refresh ever needed
	always_ff @(posedge clock) begin
		if (rst) begin
			state <= IDLE;
			opWrite <= 1'b0;
			opLanes <= 2'b00;
		end else begin
			case (state)
				IDLE: begin
					if (retainRequest) begin
						state <= RETAIN;
					end else if (reqValid && reqLanes != 2'b00) begin
						opWrite <= reqWrite;
						opLanes <= reqLanes;
						state <= SETUP;
					end
				end
				SETUP: begin
					state <= opWrite ? WINDOW : READ;
				end
				WINDOW: begin
					if (timerDone) begin
						state <= RECOVER;
					end
				end
				RECOVER: begin
					state <= IDLE;
				end
				READ: begin
					if (timerDone) begin
						state <= RELEASE;
					end
				end
				RELEASE: begin
					if (timerDone) begin
						state <= IDLE;
					end
				end
				RETAIN: begin
					if (!retainRequest) begin
						state <= IDLE;
					end
				end
				default: begin
					state <= IDLE;
				end
			endcase
		end
	end

	// Timer loads on entry to each timed phase
	always_comb begin
		timerLoad = 1'b0;
		timerCount = '0;
		if (state == SETUP) begin
			timerLoad = 1'b1;
			timerCount = opWrite ? TW'(`WRITE_WINDOW_CYCLES - 1)
				: TW'(`READ_ACCESS_CYCLES - 1);
		end else if (state == READ && timerDone) begin
			timerLoad = 1'b1;
			timerCount = TW'(`RELEASE_CYCLES - 1);
		end
	end

	// Address and write data latched once, so they stay put across the window
	always_ff @(posedge clock) begin
		if (rst) begin
			word_address <= '0;
			shared_data_bus_out <= '0;
		end else if (state == IDLE && reqValid && !retainRequest) begin
			word_address <= reqAddress;
			shared_data_bus_out <= reqData;
		end
	end

	// Pin controls; selects drop only on the edge after the window ends
	always_ff @(posedge clock) begin
		if (rst) begin
			select_active_low <= 1'b1;
			select_active_high <= 1'b0;
			writeStrobe_n <= 1'b1;
			outputGate_n <= 1'b1;
			low_lane_select_n <= 1'b1;
			high_lane_select_n <= 1'b1;
			shared_data_bus_oe <= '0;
		end else begin
			select_active_low <= !(state == SETUP || state == WINDOW || state == READ);
			// High select held at a full low level in retention
			select_active_high <= (state == SETUP || state == WINDOW || state == READ);
			writeStrobe_n <= !(state == SETUP && opWrite) && !(state == WINDOW && !timerDone);
			outputGate_n <= !(state == SETUP && !opWrite) && !(state == READ);
			low_lane_select_n <= !((state == SETUP || state == WINDOW || state == READ)
				&& opLanes[0]);
			high_lane_select_n <= !((state == SETUP || state == WINDOW || state == READ)
				&& opLanes[1]);
			// Drive only the chosen lanes while writing; device drives on reads
			if (state == SETUP && opWrite) begin
				shared_data_bus_oe <= laneMask(opLanes);
			end else if (state == WINDOW && timerDone) begin
				shared_data_bus_oe <= '0;
			end else if (state != WINDOW) begin
				shared_data_bus_oe <= '0;
			end
		end
	end

	// Read capture at the end of the access time, unused lane reads zero
	always_ff @(posedge clock) begin
		if (rst) begin
			readValid <= 1'b0;
			readData <= '0;
		end else begin
			readValid <= (state == READ && timerDone);
			if (state == READ && timerDone) begin
				readData <= shared_data_bus_in & laneMask(opLanes);
			end
		end
	end

	// Handshake outputs
	always_ff @(posedge clock) begin
		if (rst) begin
			reqReady <= 1'b0;
			retainActive <= 1'b0;
		end else begin
			reqReady <= (state == IDLE) && !(reqValid && !retainRequest && reqLanes != 2'b00);
			retainActive <= (state == RETAIN);
		end
	end
endmodule

// [verif/sram_host_asserts.sv]
`timescale 1ns/100ps
module sram_host_asserts (
	input wire logic        clock,
	input wire logic        rst,
	input wire logic        reqReady,
	input wire logic        readValid,
	input wire logic        select_active_low,
	input wire logic        select_active_high,
	input wire logic        writeStrobe_n,
	input wire logic        outputGate_n,
	input wire logic        low_lane_select_n,
	input wire logic        high_lane_select_n,
	input wire logic [15:0] shared_data_bus_oe
);
	default clocking @(posedge clock); endclocking
	default disable iff (rst);
	// Device counts as selected only with both selects active
	wire chipOn = !select_active_low && select_active_high;
	sequence strobeDrop; $fell(writeStrobe_n); endsequence
	sequence gateDrop; $fell(outputGate_n); endsequence
	chk_strobe_needs_sel: assert property (!writeStrobe_n |-> chipOn)
		else $error("write strobe low while deselected");
	chk_window_width: assert property (strobeDrop |=> !writeStrobe_n)
		else $error("write window shorter than two cycles");
	chk_sel_outlasts: assert property ($rose(writeStrobe_n) |-> chipOn)
		else $error("select dropped before window closed");
	chk_no_drive_read: assert property (!outputGate_n |-> shared_data_bus_oe == 16'h0)
		else $error("host drives bus during read");
	chk_oe_in_window: assert property (shared_data_bus_oe != 16'h0 |-> !writeStrobe_n)
		else $error("host drives bus outside write window");
	chk_lane_needs_sel: assert property (!(low_lane_select_n && high_lane_select_n) |-> chipOn)
		else $error("lane select low while deselected");
	chk_idle_deselect: assert property (reqReady |-> select_active_low && !select_active_high)
		else $error("device selected while idle");
	chk_read_answer: assert property (gateDrop |-> ##[1:5] readValid ##1 !readValid)
		else $error("read answer missing or not a pulse");
endmodule
bind sram_host sram_host_asserts i_chk (.*);

// [verif/sram_model.sv]
`timescale 1ns/100ps
module sram_model (
	input wire logic [17:0] word_address,
	input wire logic        select_active_low,
	input wire logic        select_active_high,
	input wire logic        writeStrobe_n,
	input wire logic        outputGate_n,
	input wire logic        low_lane_select_n,
	input wire logic        high_lane_select_n,
	input wire logic [15:0] busIn,
	output logic     [15:0] busOut,
	output logic     [15:0] busOe
);
	// Plain array: no clock and no refresh, contents just persist
	logic [15:0] mem [0:262143];
	// Both selects together gate everything else, lanes both high mean standby
	wire on = !select_active_low && select_active_high;
	// Data seen 1 ns late: the host drops its drive on the closing edge (zero hold),
	// so the store must not race that release
	wire [15:0] busLate;
	assign #1 busLate = busIn;
	// Store on window close; lanes still low then, so each lane is honoured
	always @(posedge writeStrobe_n) begin
		if (on && !low_lane_select_n) mem[word_address][7:0] = busLate[7:0];
		if (on && !high_lane_select_n) mem[word_address][15:8] = busLate[15:8];
	end
	// Drive only the read lanes; release is immediate, never later than drive
	assign busOut = mem[word_address];
	assign busOe = (on && writeStrobe_n && !outputGate_n) ?
		{{8{!high_lane_select_n}}, {8{!low_lane_select_n}}} : 16'h0;
endmodule

// [verif/tb.sv]
`timescale 1ns/100ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic        clock, rst, reqValid, reqWrite, retainRequest;
	logic        reqReady, readValid, retainActive, sAl, sAh, wS, oG, lL, hL;
	logic [1:0]  reqLanes;
	logic [17:0] reqAddress, addr;
	logic [15:0] reqData, readData, hostOut, hostOe, devOut, devOe, busIn, noise;
	int          err_total, check_count, cycles;
	// Row: write, lanes, address, data, expected read
	logic [52:0] rows [9] = '{{1'b1, 2'h3, 18'h00001, 16'h1234, 16'h0000},
		{1'b1, 2'h1, 18'h00001, 16'h99AB, 16'h0000}, {1'b1, 2'h2, 18'h00001, 16'hCD77, 16'h0000},
		{1'b0, 2'h3, 18'h00001, 16'h0000, 16'hCDAB}, {1'b0, 2'h1, 18'h00001, 16'h0000, 16'h00AB},
		{1'b0, 2'h2, 18'h00001, 16'h0000, 16'hCD00}, {1'b1, 2'h3, 18'h3FFFF, 16'hFFFF, 16'h0000},
		{1'b1, 2'h3, 18'h00000, 16'h5A5A, 16'h0000}, {1'b0, 2'h3, 18'h3FFFF, 16'h0000, 16'hFFFF}};
	sram_host i_dut (.clock(clock), .rst(rst), .reqValid(reqValid), .reqWrite(reqWrite),
		.reqLanes(reqLanes), .reqAddress(reqAddress), .reqData(reqData),
		.retainRequest(retainRequest), .reqReady(reqReady), .readValid(readValid),
		.readData(readData), .retainActive(retainActive), .word_address(addr),
		.select_active_low(sAl), .select_active_high(sAh), .writeStrobe_n(wS),
		.outputGate_n(oG), .low_lane_select_n(lL), .high_lane_select_n(hL),
		.shared_data_bus_in(busIn), .shared_data_bus_out(hostOut), .shared_data_bus_oe(hostOe));
	sram_model i_mem (.word_address(addr), .select_active_low(sAl), .select_active_high(sAh),
		.writeStrobe_n(wS), .outputGate_n(oG), .low_lane_select_n(lL),
		.high_lane_select_n(hL), .busIn(busIn), .busOut(devOut), .busOe(devOe));
	// Undriven lines toggle so a stale value can never pass for data
	assign busIn = (hostOut & hostOe) | (devOut & devOe) | (noise & ~hostOe & ~devOe);
	initial begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end
	// Hang guard, generous for about a dozen transfers
	always @(posedge clock) begin
		noise <= ~noise;
		cycles <= cycles + 1;
		if (cycles == 2000) begin
			err_total++;
			final_report();
		end
	end
	task automatic req(input logic [52:0] r);
		int n;
		// Raise only once ready shows an idle sequencer, so one take edge follows
		n = 0;
		do @(negedge clock); while (reqReady !== 1'b1 && ++n < 20);
		@(posedge clock);
		{reqWrite, reqLanes, reqAddress, reqData} <= r[52:16];
		reqValid <= 1'b1;
		@(posedge clock);
		reqValid <= 1'b0;
		n = 0;
		do @(negedge clock); while ((r[52] ? reqReady : readValid) !== 1'b1 && ++n < 20);
		`CHK(n < 20, 1'b1)
		if (!r[52]) `CHK(readData, r[15:0])
	endtask
	task final_report;
		$display("checks %0d errors %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	initial begin
		{rst, reqValid, reqWrite, retainRequest} = 4'h8;
		{reqLanes, reqAddress, reqData, noise, cycles} = '0;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK({sAl, sAh, wS, oG, lL, hL, hostOe}, {6'h2F, 16'h0})
		foreach (rows[i]) req(rows[i]);
		// Retention from idle: both selects parked at full inactive levels
		@(posedge clock);
		retainRequest <= 1'b1;
		repeat (6) @(negedge clock);
		`CHK({retainActive, sAl, sAh}, 3'h6)
		@(posedge clock);
		retainRequest <= 1'b0;
		req({1'b0, 2'h3, 18'h00001, 16'h0000, 16'hCDAB});
		// Reset lands on the closing edge of a write window; pins must park at once
		@(posedge clock);
		{reqWrite, reqLanes, reqAddress, reqData} <= {1'b1, 2'h3, 18'h00002, 16'hBEEF};
		reqValid <= 1'b1;
		@(posedge clock);
		reqValid <= 1'b0;
		repeat (2) @(negedge clock);
		`CHK(wS, 1'b0)
		@(posedge clock);
		rst <= 1'b1;
		// Two edges of reset, so the forced strobe rise is never seen as a window end
		repeat (2) @(posedge clock);
		rst <= 1'b0;
		@(negedge clock);
		`CHK({sAl, sAh, wS, oG, lL, hL, hostOe, readValid, reqReady}, {6'h2F, 16'h0, 2'h0})
		req({1'b0, 2'h3, 18'h00001, 16'h0000, 16'hCDAB});
		final_report();
	end
endmodule
